// ==== src/adcm_defines.vh ====
`ifndef ADCM_DEFINES_VH
`define ADCM_DEFINES_VH
// register byte offsets on the apb window
`define ADCM_OFF_CTL2      12'h000
`define ADCM_OFF_DBG       12'h004
`define ADCM_OFF_TEST      12'h008
`define ADCM_OFF_PORT      12'h00C
`define ADCM_OFF_RES0      12'h010
`define ADCM_OFF_STATE     12'h030
// control two field positions
`define ADCM_CTL2_PU_BIT   7
`define ADCM_CTL2_HALT_IN_WAIT_BIT 6
// debug control field positions
`define ADCM_DBG_FRZ_BIT   0
// test register field positions
`define ADCM_TST_SEL_LSB   0
`define ADCM_TST_OUT_BIT   4
`define ADCM_TST_RST_BIT   5
// reset values
`define ADCM_CTL2_RST      8'h00
`define ADCM_DBG_RST       8'h00
`define ADCM_TEST_RST      8'h00
// stop recovery time in ns and cycles at 100 MHz
`define ADCM_TSR_NS        10000
`define ADCM_CLK_NS        10
`define ADCM_TSR_CYC       (`ADCM_TSR_NS / `ADCM_CLK_NS)
// conversion length in cycles for the stand-in core
`define ADCM_CONV_CYC      16'h0010
// last index of the conversion countdown per sequence length
`define ADCM_SEQ4_LAST     4'h3
`define ADCM_SEQ8_LAST     4'h7
`endif

// ==== src/adcm_sync.v ====
`timescale 1ns/100ps
// two flop synchroniser for a bus of pin levels
module adcm_sync #(
  parameter W = 8
) (
  // clock and reset
  input  wire         pclk,
  input  wire         presetn,
  // data
  input  wire [W-1:0] din,
  output wire [W-1:0] dout
);
  reg [W-1:0] meta_reg;  // first stage, read only by the second
  reg [W-1:0] sync_reg;  // second stage
  // pins carry no stored value after reset, zero only until two edges pass
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= {W{1'b0}};
      sync_reg <= {W{1'b0}};
    end else begin
      meta_reg <= din;
      sync_reg <= meta_reg;
    end
  end
  assign dout = sync_reg;
endmodule // adcm_sync

// ==== src/adcm_ctrl.v ====
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/100ps
`include "adcm_defines.vh"
// Operation
// - soft reset bit restores power-on state
// - power-up bit survives the soft reset
// - four test bits plus test-output mux
// - port register reads live pin levels
// - port bits follow pins, no store
// - port register writes do nothing
// - results left-justified in 16-bit pair
// - result registers have no reset value
// - result registers read-only, writes ignored
// - result slot follows conversion mode
// - stop aborts running sequence
// - stop halts only when stop-disable clear
// - wait stop recovery before new sequence
// - wait mode halts only with halt-in-wait
// - debug mode obeys debug control register
// - power-up clear stops converter, bus stays
// - test registers zero in normal mode
module adcm_ctrl #(
  parameter NRES    = 8,                 // number of result registers
  parameter RES_W   = 10,                // converter resolution
  parameter TSR_CYC = `ADCM_TSR_CYC      // stop recovery in cycles
) (
  // apb slave
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // analog port pins, digital view
  input  wire [7:0]  analog_pin_level_bits,
  // system mode inputs
  input  wire        special_mode,
  input  wire        stop_req,
  input  wire        stop_disable,
  input  wire        wait_req,
  input  wire        debug_active,
  // converter core side
  input  wire        conv_start,
  input  wire [1:0]  conv_mode,
  input  wire [2:0]  conv_chan,
  input  wire [RES_W-1:0] conv_value,
  output wire        converter_enable,
  output reg         conv_busy,
  output wire        clock_halted,
  output reg         test_mux_output
);
  // control registers
  reg  [7:0]  ctl2_reg;          // converter_control_two
  reg  [7:0]  ctl2_next;
  reg  [7:0]  dbg_reg;           // converter_debug_control
  reg  [3:0]  tst_sel_reg;       // factory_test_select
  reg         tst_out_reg;       // test output mux enable
  reg         soft_rst_reg;      // module soft reset request
  // sequencing state
  reg  [1:0]  state_reg;
  reg  [1:0]  state_next;
  reg  [15:0] cnt_reg;           // conversion or recovery counter
  reg  [2:0]  ptr_reg;           // result slot being written next
  reg  [3:0]  left_reg;          // conversions still owed after the current one
  reg  [1:0]  mode_reg;          // latched conversion mode
  reg  [15:0] res_mem [0:NRES-1];// results, no reset by design
  wire [7:0]  pin_sync;
  wire        apb_wr;
  wire        apb_rd;
  wire        pu;
  wire        halt;
  wire [2:0]  slot;
  wire [15:0] res_left;
  integer     i;

  localparam [1:0] ST_IDLE = 2'b00;  // nothing running
  localparam [1:0] ST_CONV = 2'b01;  // conversion in progress
  localparam [1:0] ST_REC  = 2'b10;  // stop recovery delay

  // behaviour in brief, for whoever picks this block up next:
  //
  // register side
  //   control two holds the power-up bit and the halt-in-wait bit.
  //   debug control holds the freeze-in-debug bit.
  //   the test register only exists while special_mode is high;
  //   in normal mode it reads zero and swallows writes, so a
  //   stray write from field software can never trigger a soft
  //   reset or flip the test mux.
  //   the port register is a live view of the pins, two flops
  //   late; it has no storage of its own, so writes are dropped.
  //   result words are read-only from the bus; only the sequencer
  //   writes them, and they carry no reset value, so a read before
  //   the first conversion returns whatever the flops hold.
  //
  // soft reset
  //   the soft reset bit lives one cycle only. during that cycle
  //   every control and test register and the sequencer go back to their reset
  //   values, except the power-up bit, which software expects to
  //   stay set so the converter does not need to settle again.
  //
  // sequencing
  //   a start pulse is taken only in idle and only when nothing
  //   holds the converter. a sequence is four conversions in mode
  //   zero and eight otherwise; each lasts a fixed count of
  //   cycles, and the value on conv_value is captured at its end.
  //   after the last conversion the block returns to idle.
  //
  // stop, wait and debug
  //   a stop that really halts clocks aborts a running sequence.
  //   recovery is owed after any such stop, even from idle,
  //   because the analog side was powered down either way; the
  //   recovery count only runs once the stop has lifted.
  //   wait mode halts progress only with halt-in-wait set, and
  //   debug mode only with the freeze bit set; in both cases the
  //   sequence resumes where it was, nothing is lost.
  //
  // limitation
  //   software should still allow the converter to settle after
  //   setting power-up; the block itself does not enforce that
  //   delay, it only refuses to convert while power-up is clear.

  // pins cross into the bus clock before anyone reads them
  adcm_sync #(.W(8)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (analog_pin_level_bits),
    .dout    (pin_sync)
  );

  // zero wait state slave, never errors
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign apb_wr  = psel & penable & pwrite;
  assign apb_rd  = psel & ~penable & ~pwrite;

  assign pu               = ctl2_reg[`ADCM_CTL2_PU_BIT];
  assign converter_enable = pu;
  // stop halts clocks only when the stop-disable bit is clear
  assign clock_halted = stop_req & ~stop_disable;
  // any condition that freezes conversion progress
  assign halt = ~pu
              | clock_halted
              | (wait_req & ctl2_reg[`ADCM_CTL2_HALT_IN_WAIT_BIT])
              | (debug_active & dbg_reg[`ADCM_DBG_FRZ_BIT]);

  // slot depends on mode: mode 0 four slots, else eight
  assign slot = (mode_reg == 2'b00) ? {1'b0, ptr_reg[1:0]} : ptr_reg;
  // value packed toward the msb of the 16-bit pair
  assign res_left = {conv_value, {(16-RES_W){1'b0}}};

  // control two: soft reset clears all but power-up
  always @* begin
    ctl2_next = ctl2_reg;
    if (soft_rst_reg) begin
      ctl2_next = `ADCM_CTL2_RST;
      ctl2_next[`ADCM_CTL2_PU_BIT] = ctl2_reg[`ADCM_CTL2_PU_BIT];
    end else if (apb_wr && paddr == `ADCM_OFF_CTL2) begin
      ctl2_next = pwdata[7:0];
    end
  end

  // register writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl2_reg     <= `ADCM_CTL2_RST;
      dbg_reg      <= `ADCM_DBG_RST;
      tst_sel_reg  <= 4'h0;
      tst_out_reg  <= 1'b0;
      soft_rst_reg <= 1'b0;
    end else begin
      ctl2_reg <= ctl2_next;
      if (soft_rst_reg) begin
        // bit self clears after one cycle of module reset
        dbg_reg      <= `ADCM_DBG_RST;
        tst_sel_reg  <= 4'h0;
        tst_out_reg  <= 1'b0;
        soft_rst_reg <= 1'b0;
      end else if (apb_wr) begin
        if (paddr == `ADCM_OFF_DBG) begin
          dbg_reg <= pwdata[7:0];
        end else if (paddr == `ADCM_OFF_TEST && special_mode) begin
          // test writes only act in special mode
          tst_sel_reg  <= pwdata[`ADCM_TST_SEL_LSB+3:`ADCM_TST_SEL_LSB];
          tst_out_reg  <= pwdata[`ADCM_TST_OUT_BIT];
          soft_rst_reg <= pwdata[`ADCM_TST_RST_BIT];
        end
        // port and result offsets: writes fall through untouched
      end
    end
  end

  // test mux: selected internal signal appears when enabled
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      test_mux_output <= 1'b0;
    end else if (!tst_out_reg) begin
      test_mux_output <= 1'b0;
    end else begin
      case (tst_sel_reg)
        4'h0:    test_mux_output <= conv_busy;
        4'h1:    test_mux_output <= halt;
        4'h2:    test_mux_output <= pu;
        4'h3:    test_mux_output <= clock_halted;
        default: test_mux_output <= ^{tst_sel_reg, ptr_reg};
      endcase
    end
  end

  // sequencing: start, abort on stop, recovery wait
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (clock_halted) begin
          // an idle stop still owes the recovery delay
          state_next = ST_REC;
        end else if (conv_start && !halt) begin
          state_next = ST_CONV;
        end
      end
      ST_CONV: begin
        if (clock_halted) begin
          state_next = ST_REC;
        end else if (!pu) begin
          state_next = ST_IDLE;
        end else if (!halt && cnt_reg == 16'h0000 && left_reg == 4'h0) begin
          // last slot of the sequence written: back to idle
          state_next = ST_IDLE;
        end
      end
      ST_REC: begin
        // recovery counts only once stop lifts
        if (!clock_halted && cnt_reg == 16'h0000) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // sequence counters
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= 16'h0000;
      ptr_reg   <= 3'h0;
      left_reg  <= 4'h0;
      mode_reg  <= 2'b00;
      conv_busy <= 1'b0;
    end else if (soft_rst_reg) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= 16'h0000;
      ptr_reg   <= 3'h0;
      left_reg  <= 4'h0;
      mode_reg  <= 2'b00;
      conv_busy <= 1'b0;
    end else begin
      state_reg <= state_next;
      conv_busy <= (state_next == ST_CONV);
      case (state_reg)
        ST_IDLE: begin
          if (state_next == ST_REC) begin
            cnt_reg <= TSR_CYC[15:0] - 16'h0001;
          end else if (state_next == ST_CONV) begin
            cnt_reg  <= `ADCM_CONV_CYC - 16'h0001;
            mode_reg <= conv_mode;
            ptr_reg  <= conv_chan;
            // sequence length follows the mode
            if (conv_mode == 2'b00) begin
              left_reg <= `ADCM_SEQ4_LAST;
            end else begin
              left_reg <= `ADCM_SEQ8_LAST;
            end
          end
        end
        ST_CONV: begin
          if (state_next == ST_REC) begin
            cnt_reg <= TSR_CYC[15:0] - 16'h0001;
          end else if (!halt) begin
            if (cnt_reg == 16'h0000) begin
              cnt_reg <= `ADCM_CONV_CYC - 16'h0001;
              ptr_reg <= ptr_reg + 3'h1;
              // guarded so the count never wraps at sequence end
              if (left_reg != 4'h0) begin
                left_reg <= left_reg - 4'h1;
              end
            end else begin
              cnt_reg <= cnt_reg - 16'h0001;
            end
          end
        end
        ST_REC: begin
          if (!clock_halted && cnt_reg != 16'h0000) begin
            cnt_reg <= cnt_reg - 16'h0001;
          end
        end
        default: cnt_reg <= 16'h0000;
      endcase
    end
  end

  // result store: written only by the converter, never by the bus
  always @(posedge pclk) begin
    if (state_reg == ST_CONV && !halt && !soft_rst_reg && cnt_reg == 16'h0000) begin
      res_mem[slot] <= res_left;
    end
  end

  // read mux, registered on the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (apb_rd) begin
      prdata <= 32'h00000000;
      if (paddr == `ADCM_OFF_CTL2) begin
        prdata[7:0] <= ctl2_reg;
      end else if (paddr == `ADCM_OFF_DBG) begin
        prdata[7:0] <= dbg_reg;
      end else if (paddr == `ADCM_OFF_TEST) begin
        // normal mode shows zero
        if (special_mode) begin
          prdata[7:0] <= {2'b00, soft_rst_reg, tst_out_reg, tst_sel_reg};
        end
      end else if (paddr == `ADCM_OFF_PORT) begin
        prdata[7:0] <= pin_sync;
      end else if (paddr == `ADCM_OFF_STATE) begin
        prdata[7:0] <= {conv_busy, state_reg, ptr_reg, halt, pu};
      end else begin
        for (i = 0; i < NRES; i = i + 1) begin
          if (paddr == `ADCM_OFF_RES0 + i[11:0] * 12'h004) begin
            prdata[15:0] <= res_mem[i];
          end
        end
      end
    end
  end
endmodule // adcm_ctrl

// ==== tb/adcm_ctrl_chk.sv ====
`timescale 1ns/100ps
// port-level checker for the converter control block
module adcm_ctrl_chk #(
  parameter RES_W   = 10,
  parameter TSR_CYC = 20
) (
  input wire             pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire [11:0]      paddr,
  input wire [31:0]      pwdata, prdata,
  input wire [7:0]       analog_pin_level_bits,
  input wire             special_mode, stop_req, stop_disable, wait_req, debug_active,
  input wire             conv_start, converter_enable, conv_busy, clock_halted, test_mux_output,
  input wire [1:0]       conv_mode,
  input wire [2:0]       conv_chan,
  input wire [RES_W-1:0] conv_value
);
  reg [7:0]  pd1, pd2; // pin history, a read is judged only on settled pins
  reg [15:0] rec_cnt;  // recovery cycles still owed after a stop
  wire rd = psel && !penable && !pwrite;
  wire wr = psel && penable && pwrite;
  // track pins and the stop recovery window
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd1 <= 8'h00;
      pd2 <= 8'h00;
      rec_cnt <= 16'h0000;
    end else begin
      pd1 <= analog_pin_level_bits;
      pd2 <= pd1;
      if (clock_halted) rec_cnt <= 16'(TSR_CYC);
      else if (rec_cnt != 16'h0000) rec_cnt <= rec_cnt - 16'h0001;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_HALT: assert property (clock_halted == (stop_req && !stop_disable))
    else $error("halt mismatch");
  AST_PORT: assert property (rd && paddr == 12'h00C && analog_pin_level_bits == pd1 && pd1 == pd2
    |=> prdata == {24'h000000, $past(analog_pin_level_bits)}) else $error("port read wrong");
  AST_TEST0: assert property (rd && paddr == 12'h008 && !special_mode |=> prdata == 32'h0)
    else $error("test read not zero");
  AST_PU: assert property (wr && paddr == 12'h000 |=> converter_enable == $past(pwdata[7]))
    else $error("power-up bit wrong");
  AST_CTLRD: assert property (rd && paddr == 12'h000 |=> prdata[7] == converter_enable)
    else $error("control read wrong");
  AST_ABORT: assert property (clock_halted |=> !conv_busy)
    else $error("stop did not abort");
  AST_REC: assert property (rec_cnt > 16'h0001 |-> !conv_busy)
    else $error("start during recovery");
  AST_START: assert property (conv_start && converter_enable && !clock_halted && !wait_req && !debug_active
    && !conv_busy && rec_cnt == 16'h0000 |=> conv_busy) else $error("start ignored");
  AST_SRST: assert property (wr && paddr == 12'h008 && special_mode && pwdata[5]
    |=> ##1 !conv_busy && converter_enable == $past(converter_enable, 2)) else $error("soft reset wrong");
endmodule // adcm_ctrl_chk

bind adcm_ctrl adcm_ctrl_chk #(.RES_W(RES_W), .TSR_CYC(TSR_CYC)) u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .analog_pin_level_bits(analog_pin_level_bits),
  .special_mode(special_mode), .stop_req(stop_req), .stop_disable(stop_disable), .wait_req(wait_req),
  .debug_active(debug_active), .conv_start(conv_start), .converter_enable(converter_enable),
  .conv_busy(conv_busy), .clock_halted(clock_halted), .test_mux_output(test_mux_output),
  .conv_mode(conv_mode), .conv_chan(conv_chan), .conv_value(conv_value));

// ==== tb/adcm_ctrl_tb.sv ====
`timescale 1ns/100ps
// self-checking bench for the converter control block
module adcm_ctrl_tb;
  localparam TSR = 20; // stop recovery shortened for simulation
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        special_mode = 0, stop_req = 0, stop_disable = 0, wait_req = 0, debug_active = 0;
  logic        conv_start = 0, converter_enable, conv_busy, clock_halted, test_mux_output;
  logic [1:0]  conv_mode = 2'h0;
  logic [2:0]  conv_chan = 3'h0;
  logic [9:0]  conv_value = 10'h000, v1, v2;
  logic [7:0]  pins = 8'h00;
  logic [31:0] exq[$]; // expected read data, oldest first
  integer      n_errors = 0, n_compared = 0, i;
  always #5 pclk = ~pclk;
  adcm_ctrl #(.TSR_CYC(TSR)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .analog_pin_level_bits(pins), .special_mode(special_mode), .stop_req(stop_req),
    .stop_disable(stop_disable), .wait_req(wait_req), .debug_active(debug_active), .conv_start(conv_start),
    .conv_mode(conv_mode), .conv_chan(conv_chan), .conv_value(conv_value), .converter_enable(converter_enable),
    .conv_busy(conv_busy), .clock_halted(clock_halted), .test_mux_output(test_mux_output));
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task conclude;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // one apb transfer, held until pready is seen high
  task apb(input bit w, input [11:0] a, input [31:0] d, input [31:0] e);
    integer k;
    if (!w) exq.push_back(e);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk); penable <= 1'b1;
    k = 0;
    do begin @(posedge pclk); k = k + 1; end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin n_errors = n_errors + 1; conclude; end
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  // pulse a start, check whether it was taken, wait for the end
  task run(input [1:0] m, input [9:0] v, input bit go);
    integer k;
    conv_mode <= m; conv_value <= v; conv_start <= 1'b1;
    @(posedge pclk); conv_start <= 1'b0;
    @(negedge pclk);
    check("conv_busy", {31'h0, conv_busy}, {31'h0, go});
    k = 0;
    while (conv_busy !== 1'b0 && k < 600) begin @(negedge pclk); k = k + 1; end
    if (k >= 600) begin n_errors = n_errors + 1; conclude; end
    @(posedge pclk);
  endtask
  // compare each completed read with the oldest note
  always @(posedge pclk)
    if (psel && penable && !pwrite && pready === 1'b1) check("prdata", prdata, exq.pop_front());
  initial begin
    i = $urandom(12);
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, 12'h000, 0, 0); apb(0, 12'h004, 0, 0); apb(0, 12'h008, 0, 0);
    run(2'h1, 10'h155, 1'b0);
    for (i = 0; i < 4; i = i + 1) begin
      pins <= 8'($urandom); repeat (3) @(posedge pclk);
      apb(1, 12'h00C, 32'hFF, 0); apb(0, 12'h00C, 0, {24'h0, pins});
    end
    apb(1, 12'h000, 32'hC0, 0);
    repeat (10000) @(posedge pclk);
    apb(0, 12'h000, 0, 32'hC0); apb(1, 12'h000, 32'h80, 0);
    apb(1, 12'h004, 32'h01, 0); apb(0, 12'h004, 0, 32'h01); apb(1, 12'h004, 32'h00, 0);
    v1 = 10'($urandom); v2 = ~v1; wait_req <= 1'b1;
    run(2'h1, v1, 1'b1);
    wait_req <= 1'b0; debug_active <= 1'b1;
    run(2'h0, v2, 1'b1);
    debug_active <= 1'b0;
    for (i = 0; i < 8; i = i + 1) apb(0, 12'h010 + 4 * i, 0, {16'h0, (i < 4) ? v2 : v1, 6'h0});
    apb(1, 12'h010, 32'hFFFF, 0); apb(0, 12'h010, 0, {16'h0, v2, 6'h0});
    conv_start <= 1'b1; @(posedge pclk); conv_start <= 1'b0; repeat (5) @(posedge pclk);
    stop_req <= 1'b1; @(posedge pclk); @(negedge pclk);
    check("conv_busy", {31'h0, conv_busy}, 0);
    @(posedge pclk); stop_req <= 1'b0;
    run(2'h1, v1, 1'b0);
    repeat (TSR + 5) @(posedge pclk);
    run(2'h1, v1, 1'b1);
    stop_disable <= 1'b1; stop_req <= 1'b1; @(posedge pclk); @(negedge pclk);
    check("clock_halted", {31'h0, clock_halted}, 0);
    @(posedge pclk);
    stop_req <= 1'b0; stop_disable <= 1'b0; special_mode <= 1'b1; @(posedge pclk);
    apb(1, 12'h000, 32'hC0, 0); apb(1, 12'h008, 32'h01, 0); apb(0, 12'h008, 0, 32'h01);
    apb(1, 12'h008, 32'h12, 0); @(negedge pclk);
    check("test_mux_output", {31'h0, test_mux_output}, 1);
    @(posedge pclk);
    apb(1, 12'h008, 32'h20, 0); apb(0, 12'h000, 0, 32'h80); apb(0, 12'h008, 0, 0);
    special_mode <= 1'b0;
    apb(1, 12'h008, 32'h01, 0); apb(0, 12'h008, 0, 0);
    conclude;
  end
endmodule // adcm_ctrl_tb
